// *** include/iopad_pkg.sv ***
// constants for the i/o processor address decoder
//
// Operation
// - four 2K prom, sixteen 1K ram banks
// - ports at 80h plus offset 0-7fh
// - ports aliased in memory at 8000h
// - address bit 8 ignored by port decode
// - high counter port takes target, 5 bits
// - low counter port takes 7 bits
// - six control-store bytes, read and write
// - read port returns pending interrupt requests
// - clear ports for dma, time, mouse
// - write-only control, clock, comm ports latched
package iopad_pkg;
  // ==========================================================
  // memory map
  localparam logic [2:0]  PROM_REGION   = 3'h0;
  localparam logic [1:0]  RAM_LO_REGION = 2'h1;
  localparam logic [1:0]  RAM_HI_REGION = 2'h2;
  localparam logic [15:0] PORT_BASE     = 16'h0080;
  localparam logic [15:0] MMIO_BASE     = 16'h8000;
  localparam int          MMIO_BIT      = 15;
  localparam int          PROM_BANKS    = 4;
  localparam int          RAM_BANKS     = 8;
  localparam int          CS_BYTES      = 6;

  // ==========================================================
  // port offsets p (port = 80h + p)
  localparam logic [6:0] P_TASK_COUNTER_HIGH_LOAD  = 7'h41;
  localparam logic [6:0] P_TASK_COUNTER_LOW_LOAD   = 7'h42;
  localparam logic [6:0] P_CS_BASE   = 7'h44;
  localparam logic [6:0] P_INTR_REQ  = 7'h60;
  localparam logic [6:0] P_CP_INPUT  = 7'h62;
  localparam logic [6:0] P_CP_STATE  = 7'h63;
  localparam logic [6:0] P_CLOCKS    = 7'h68;
  localparam logic [6:0] P_TOD_CLR   = 7'h69;
  localparam logic [6:0] P_COM_OUT   = 7'h6a;
  localparam logic [6:0] P_CP_CTRL   = 7'h6b;
  localparam logic [6:0] P_MOUSE_CLR = 7'h6c;
  localparam logic [6:0] P_DMA_CLR   = 7'h6d;
  localparam logic [6:0] P_CTRL1     = 7'h6e;

  // ==========================================================
  // field layout and reset values
  localparam int         TPC_HI_BITS = 5;
  localparam int         TPC_LO_BITS = 7;
  localparam int         TPC_SEL_LSB = 5;
  localparam logic [7:0] BYTE_RST    = 8'h00;
  localparam logic [2:0] TPC_SEL_RST = 3'h0;
  localparam logic [11:0] TPC_RST    = 12'h000;
endpackage : iopad_pkg

// *** rtl/iopad_decoder.sv ***
// address decode and port registers of the i/o processor
`timescale 1ns/1ps
module iopad_decoder
  import iopad_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_mem_rd,
  input  wire logic        i_mem_wr,
  input  wire logic        i_io_rd,
  input  wire logic        i_io_wr,
  input  wire logic [7:0]  i_intr_req,
  input  wire logic [7:0]  i_central_processor_input_port,
  input  wire logic        i_dma_done,
  input  wire logic        i_time_of_day_tick,
  output logic [7:0]       o_rdata,
  output logic             o_rd_ack,
  output logic [3:0]       o_prom_sel,
  output logic [7:0]       o_ram_lo_sel,
  output logic [7:0]       o_ram_hi_sel,
  output logic [2:0]       o_tpc_target,
  output logic [11:0]      o_task_program_counter,
  output logic             o_tpc_load,
  output logic [47:0]      o_cs_word,
  output logic             o_dma_done,
  output logic             o_time_of_day_intr,
  output logic             o_mouse_clr,
  output logic [7:0]       o_cp_ctrl,
  output logic [7:0]       o_ctrl1,
  output logic [7:0]       o_clocks1,
  output logic [7:0]       o_communication_output_port
);
  // ==========================================================
  // cycle qualification
  function automatic logic hit(input logic [6:0] a, input logic [6:0] p);
    hit = (a == p);
  endfunction : hit

  logic       mmio, prd, pwr, cs_hit;
  logic [6:0] port;
  logic [2:0] cs_idx;

  assign mmio   = i_addr[MMIO_BIT];
  assign prd    = i_io_rd | (i_mem_rd & mmio);
  assign pwr    = i_io_wr | (i_mem_wr & mmio);
  // offset only
  // bit 7 of the port (address bit 8) is never looked at
  assign port   = i_addr[6:0];
  assign cs_hit = (port >= P_CS_BASE) &&
                  (port <  P_CS_BASE + 7'(CS_BYTES));
  assign cs_idx = 3'(port - P_CS_BASE);

  // ==========================================================
  // memory bank selects
  logic [3:0] prom_d;
  logic [7:0] ram_lo_d, ram_hi_d;
  logic       mem_any;

  assign mem_any = (i_mem_rd | i_mem_wr) & ~mmio;

  always_comb begin
    prom_d   = '0;
    ram_lo_d = '0;
    ram_hi_d = '0;
    if (i_mem_rd && !mmio && i_addr[15:13] == PROM_REGION) begin
      prom_d[i_addr[12:11]] = 1'b1;
    end
    if (mem_any && i_addr[14:13] == RAM_LO_REGION) begin
      ram_lo_d[i_addr[12:10]] = 1'b1;
    end
    if (mem_any && i_addr[14:13] == RAM_HI_REGION) begin
      ram_hi_d[i_addr[12:10]] = 1'b1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prom_sel   <= '0;
      o_ram_lo_sel <= '0;
      o_ram_hi_sel <= '0;
    end else begin
      o_prom_sel   <= prom_d;
      o_ram_lo_sel <= ram_lo_d;
      o_ram_hi_sel <= ram_hi_d;
    end
  end

  // ==========================================================
  // task program counter load
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tpc_target           <= TPC_SEL_RST;
      o_task_program_counter <= TPC_RST;
      o_tpc_load             <= 1'b0;
    end else begin
      o_tpc_load <= 1'b0;
      if (pwr && hit(port, P_TASK_COUNTER_HIGH_LOAD)) begin
        o_tpc_target <= i_wdata[7:TPC_SEL_LSB];
        o_task_program_counter[11:TPC_LO_BITS] <=
          i_wdata[TPC_HI_BITS-1:0];
      end
      // low part
      // the low write completes the value, so it fires the load
      if (pwr && hit(port, P_TASK_COUNTER_LOW_LOAD)) begin
        o_task_program_counter[TPC_LO_BITS-1:0] <=
          i_wdata[TPC_LO_BITS-1:0];
        o_tpc_load <= 1'b1;
      end
    end
  end

  // ==========================================================
  // control store bytes
  logic [7:0] cs_q [CS_BYTES];

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < CS_BYTES; i++) begin
        cs_q[i] <= BYTE_RST;
      end
    end else begin
      if (pwr && cs_hit) begin
        cs_q[cs_idx] <= i_wdata;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < CS_BYTES; i++) begin
      o_cs_word[8*i +: 8] = cs_q[i];
    end
  end

  // ==========================================================
  // write-only control ports
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cp_ctrl                   <= BYTE_RST;
      o_ctrl1                     <= BYTE_RST;
      o_clocks1                   <= BYTE_RST;
      o_communication_output_port <= BYTE_RST;
    end else begin
      if (pwr && hit(port, P_CP_CTRL)) begin
        o_cp_ctrl <= i_wdata;
      end
      if (pwr && hit(port, P_CTRL1)) begin
        o_ctrl1 <= i_wdata;
      end
      if (pwr && hit(port, P_CLOCKS)) begin
        o_clocks1 <= i_wdata;
      end
      if (pwr && hit(port, P_COM_OUT)) begin
        o_communication_output_port <= i_wdata;
      end
    end
  end

  // ==========================================================
  // sticky flags and clear ports
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dma_done         <= 1'b0;
      o_time_of_day_intr <= 1'b0;
      o_mouse_clr        <= 1'b0;
    end else begin
      // access clears
      // a new event in the clear cycle wins, so none is lost
      if (i_dma_done) begin
        o_dma_done <= 1'b1;
      end else if ((prd | pwr) && hit(port, P_DMA_CLR)) begin
        o_dma_done <= 1'b0;
      end
      if (i_time_of_day_tick) begin
        o_time_of_day_intr <= 1'b1;
      end else if ((prd | pwr) && hit(port, P_TOD_CLR)) begin
        o_time_of_day_intr <= 1'b0;
      end
      o_mouse_clr <= (prd | pwr) && hit(port, P_MOUSE_CLR);
    end
  end

  // ==========================================================
  // read data
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = BYTE_RST;
    if (cs_hit) begin
      rdata_d = cs_q[cs_idx];
    end else begin
      case (port)
        P_INTR_REQ: rdata_d = i_intr_req;
        P_CP_INPUT: rdata_d = i_central_processor_input_port;
        P_CP_STATE: rdata_d = {6'h00, o_time_of_day_intr, o_dma_done};
        default:    rdata_d = BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata  <= BYTE_RST;
      o_rd_ack <= 1'b0;
    end else begin
      o_rd_ack <= prd;
      o_rdata  <= prd ? rdata_d : BYTE_RST;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  property p_prom_sel;
    i_mem_rd && !i_mem_wr && i_addr < 16'h2000 |=>
      o_prom_sel == (4'h1 << $past(i_addr[12:11])) && o_ram_lo_sel == 0;
  endproperty
  a_prom_sel: assert property (p_prom_sel)
    else $error("prom bank select wrong");
  property p_ram_hi;
    i_mem_wr && i_addr >= 16'h4000 && i_addr <= 16'h5fff |=>
      $onehot(o_ram_hi_sel) && o_ram_lo_sel == 0 && o_prom_sel == 0;
  endproperty
  a_ram_hi: assert property (p_ram_hi)
    else $error("upper ram bank select wrong");
  property p_alias;
    i_mem_wr && !i_io_wr && i_addr == MMIO_BASE + PORT_BASE + 16'h006a
      |=> o_communication_output_port == $past(i_wdata) && o_ram_hi_sel == 0;
  endproperty
  a_alias: assert property (p_alias)
    else $error("memory alias of port missing");
  property p_bit8;
    i_io_wr && !i_mem_wr && i_addr[6:0] == P_CP_CTRL && !i_addr[7]
      |=> o_cp_ctrl == $past(i_wdata);
  endproperty
  a_bit8: assert property (p_bit8)
    else $error("port decode depends on bit 8");
  property p_task_counter_high_load;
    i_io_wr && !i_mem_wr && i_addr[6:0] == P_TASK_COUNTER_HIGH_LOAD |=>
      o_tpc_target == $past(i_wdata[7:5]) &&
      o_task_program_counter[11:7] == $past(i_wdata[4:0]) && !o_tpc_load;
  endproperty
  a_task_counter_high_load: assert property (p_task_counter_high_load)
    else $error("high counter port not captured");
  property p_task_counter_low_load;
    i_io_wr && !i_mem_wr && i_addr[6:0] == P_TASK_COUNTER_LOW_LOAD |=>
      o_task_program_counter[6:0] == $past(i_wdata[6:0]) && o_tpc_load;
  endproperty
  a_task_counter_low_load: assert property (p_task_counter_low_load)
    else $error("low counter port not captured");
  property p_cs_rw;
    i_io_wr && !i_mem_wr && i_addr[6:0] == P_CS_BASE + 7'h2 ##1
      i_io_rd && !i_mem_rd && i_addr[6:0] == P_CS_BASE + 7'h2 &&
      !i_io_wr && !i_mem_wr
      |=> o_rd_ack && o_rdata == $past(i_wdata, 2) &&
          o_cs_word[23:16] == o_rdata;
  endproperty
  a_cs_rw: assert property (p_cs_rw)
    else $error("control store byte readback wrong");
  property p_intr_rd;
    i_io_rd && !i_mem_rd && i_addr[6:0] == P_INTR_REQ |=>
      o_rd_ack && o_rdata == $past(i_intr_req);
  endproperty
  a_intr_rd: assert property (p_intr_rd)
    else $error("interrupt request read wrong");
  property p_dma_clr;
    i_io_wr && i_addr[6:0] == P_DMA_CLR && !i_dma_done |=> !o_dma_done;
  endproperty
  a_dma_clr: assert property (p_dma_clr)
    else $error("dma complete not cleared");
  property p_dma_set;
    i_dma_done |=> o_dma_done;
  endproperty
  a_dma_set: assert property (p_dma_set)
    else $error("dma complete event lost");
  property p_wo_read;
    i_io_rd && !i_mem_rd && i_addr[6:0] == P_CP_CTRL && !i_io_wr &&
      !i_mem_wr |=> o_rdata == 8'h00 && $stable(o_cp_ctrl);
  endproperty
  a_wo_read: assert property (p_wo_read)
    else $error("write-only port answered a read");

  c_tpc_load: cover property (o_tpc_load);
  c_cs_rw:    cover property (p_cs_rw);
  c_dma_clr:  cover property (o_dma_done ##1 !o_dma_done);
  c_alias:    cover property (i_mem_rd && i_addr[MMIO_BIT] ##1 o_rd_ack);
endmodule : iopad_decoder

// *** testbench/iopad_host.sv ***
// bus master model of the local processor driving the decoder
`timescale 1ns/1ps
module iopad_host (
  input  wire logic        i_clock,
  input  wire logic [7:0]  i_rdata,
  input  wire logic        i_rd_ack,
  output logic      [15:0] o_addr,
  output logic      [7:0]  o_wdata,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic             o_io_rd,
  output logic             o_io_wr
);
  initial begin
    o_addr   = 16'h0000;
    o_wdata  = 8'h00;
    o_mem_rd = 1'b0;
    o_mem_wr = 1'b0;
    o_io_rd  = 1'b0;
    o_io_wr  = 1'b0;
  end
  // ==========================================================
  // one strobe cycle; kind 0 mem rd, 1 mem wr, 2 io rd, 3 io wr
  task automatic cyc(input logic [1:0] kind, input logic [15:0] addr,
                     input logic [7:0] data, output logic [7:0] rd,
                     output logic ack);
    @(negedge i_clock);
    o_addr   = addr;
    o_wdata  = data;
    o_mem_rd = (kind == 2'h0);
    o_mem_wr = (kind == 2'h1);
    o_io_rd  = (kind == 2'h2);
    o_io_wr  = (kind == 2'h3);
    @(negedge i_clock);
    rd       = i_rdata;
    ack      = i_rd_ack;
    o_mem_rd = 1'b0;
    o_mem_wr = 1'b0;
    o_io_rd  = 1'b0;
    o_io_wr  = 1'b0;
    // released bus shows the inverse, not a stale value
    o_addr   = ~addr;
    o_wdata  = ~data;
  endtask : cyc

  // port write then read of the same port in back-to-back cycles
  task automatic wr_rd(input logic [15:0] addr, input logic [7:0] data,
                       output logic [7:0] rd, output logic ack);
    @(negedge i_clock);
    o_addr  = addr;
    o_wdata = data;
    o_io_wr = 1'b1;
    @(negedge i_clock);
    o_io_wr = 1'b0;
    o_io_rd = 1'b1;
    @(negedge i_clock);
    rd      = i_rdata;
    ack     = i_rd_ack;
    o_io_rd = 1'b0;
    o_addr  = ~addr;
    o_wdata = ~data;
  endtask : wr_rd
endmodule : iopad_host

// *** testbench/tb.sv ***
// self-checking bench of the i/o processor address decoder
`timescale 1ns/1ps
module tb
  import iopad_pkg::*;
;
  logic        clock, rst_n, mem_rd, mem_wr, io_rd, io_wr, ack;
  logic        dma_in, tod_in, rd_ack, tpc_load, dma_f, tod_f, mclr;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, intr, central_processor_input_port, rd, cpc, ctl1, clk1, com;
  logic [3:0]  prom;
  logic [7:0]  rlo, rhi;
  logic [2:0]  tgt;
  logic [11:0] task_program_counter;
  logic [47:0] cs;
  int          errors, checks;
  logic [15:0] m_addr [10];
  logic [19:0] m_sel  [10];

  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  iopad_host u_host (.i_clock(clock), .i_rdata(rdata), .i_rd_ack(rd_ack),
    .o_addr(addr), .o_wdata(wdata), .o_mem_rd(mem_rd), .o_mem_wr(mem_wr),
    .o_io_rd(io_rd), .o_io_wr(io_wr));

  iopad_decoder u_dut (.i_clock(clock), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_mem_rd(mem_rd), .i_mem_wr(mem_wr), .i_io_rd(io_rd),
    .i_io_wr(io_wr), .i_intr_req(intr),
    .i_central_processor_input_port(central_processor_input_port), .i_dma_done(dma_in),
    .i_time_of_day_tick(tod_in), .o_rdata(rdata), .o_rd_ack(rd_ack),
    .o_prom_sel(prom), .o_ram_lo_sel(rlo), .o_ram_hi_sel(rhi),
    .o_tpc_target(tgt), .o_task_program_counter(task_program_counter),
    .o_tpc_load(tpc_load), .o_cs_word(cs), .o_dma_done(dma_f),
    .o_time_of_day_intr(tod_f), .o_mouse_clr(mclr), .o_cp_ctrl(cpc),
    .o_ctrl1(ctl1), .o_clocks1(clk1), .o_communication_output_port(com));

  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic acc(input logic [1:0] k, input logic [15:0] a,
                     input logic [7:0] d);
    u_host.cyc(k, a, d, rd, ack);
  endtask : acc

  task automatic conclude();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // ==========================================================
  // watchdog: whole sequence needs well under 1000 cycles
  initial begin
    #50000;
    errors++;
    conclude();
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_n  = 1'b0;
    intr   = 8'h5a;
    central_processor_input_port   = 8'hc3;
    dma_in = 1'b0;
    tod_in = 1'b0;
    m_addr = '{16'h0000, 16'h0900, 16'h17ff, 16'h1800, 16'h2000,
               16'h2fff, 16'h3c00, 16'h4400, 16'h5fff, 16'h6000};
    m_sel  = '{20'h10000, 20'h20000, 20'h40000, 20'h80000, 20'h00100,
               20'h00800, 20'h08000, 20'h00002, 20'h00080, 20'h00000};
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    chk("reset", {rd_ack, tpc_load, dma_f, tod_f, mclr, cpc, task_program_counter}, 0);
    for (int i = 0; i < 10; i++) begin
      acc(2'h0, m_addr[i], 8'h00);
      chk("bank select", {prom, rlo, rhi}, m_sel[i]);
    end
    acc(2'h1, 16'h0900, 8'h11);
    chk("prom on write", prom, 4'h0);
    acc(2'h1, 16'h2400, 8'h11);
    chk("ram write", rlo, 8'h02);
    acc(2'h1, 16'h4c00, 8'h22);
    chk("ram hi write", {rlo, rhi}, 16'h0008);
    acc(2'h3, PORT_BASE | P_TASK_COUNTER_HIGH_LOAD, 8'he5);
    chk("target", tgt, 3'h7);
    acc(2'h3, PORT_BASE | P_TASK_COUNTER_LOW_LOAD, 8'hd5);
    chk("counter", {tpc_load, task_program_counter}, {1'b1, 12'h2d5});
    @(negedge clock);
    chk("load pulse", tpc_load, 1'b0);
    acc(2'h2, PORT_BASE | P_TASK_COUNTER_LOW_LOAD, 8'h00);
    chk("low read", {ack, rd}, 9'h100);
    acc(2'h0, MMIO_BASE | PORT_BASE | P_TASK_COUNTER_HIGH_LOAD, 8'h00);
    chk("high read", {ack, rd}, 9'h100);
    // bytes written without bit 7, read via alias
    for (int k = 0; k < CS_BYTES; k++) begin
      acc(2'h3, {9'h000, P_CS_BASE + 7'(k)}, {4'(k), 4'h3});
      acc(2'h0, MMIO_BASE | PORT_BASE | (P_CS_BASE + 7'(k)), 8'h00);
      chk("cs byte", {ack, rd}, {1'b1, 4'(k), 4'h3});
    end
    chk("cs word", cs, 48'h534333231303);
    u_host.wr_rd({9'h000, P_CS_BASE + 7'h2}, 8'h7e, rd, ack);
    chk("cs back to back", {ack, rd, cs[23:16]}, 17'h17e7e);
    acc(2'h3, PORT_BASE | P_INTR_REQ, 8'hff);
    acc(2'h2, PORT_BASE | P_INTR_REQ, 8'h00);
    chk("intr", {ack, rd}, 9'h15a);
    intr = 8'ha5;
    acc(2'h0, MMIO_BASE | PORT_BASE | P_INTR_REQ, 8'h00);
    chk("intr alias", {ack, rd}, 9'h1a5);
    acc(2'h2, PORT_BASE | P_CP_INPUT, 8'h00);
    chk("cp input", {ack, rd}, 9'h1c3);
    acc(2'h1, MMIO_BASE | PORT_BASE | P_CLOCKS, 8'ha1);
    acc(2'h1, MMIO_BASE | PORT_BASE | P_COM_OUT, 8'ha2);
    acc(2'h3, {9'h000, P_CP_CTRL}, 8'ha3);
    acc(2'h3, PORT_BASE | P_CTRL1, 8'ha4);
    chk("latches", {clk1, com, cpc, ctl1}, 32'ha1a2a3a4);
    acc(2'h2, PORT_BASE | P_CP_CTRL, 8'h00);
    chk("wo read", {ack, rd, cpc}, 17'h100a3);
    @(negedge clock);
    dma_in = 1'b1;
    tod_in = 1'b1;
    @(negedge clock);
    dma_in = 1'b0;
    tod_in = 1'b0;
    acc(2'h2, PORT_BASE | P_CP_STATE, 8'h00);
    chk("state", {ack, rd}, 9'h103);
    acc(2'h3, PORT_BASE | P_DMA_CLR, 8'h00);
    chk("dma clear", {dma_f, tod_f}, 2'h1);
    acc(2'h2, PORT_BASE | P_TOD_CLR, 8'h00);
    chk("tod clear", tod_f, 1'b0);
    acc(2'h3, PORT_BASE | P_MOUSE_CLR, 8'h00);
    chk("mouse clear", mclr, 1'b1);
    @(negedge clock);
    chk("mouse pulse", mclr, 1'b0);
    // event in the clear cycle keeps the flag
    dma_in = 1'b1;
    acc(2'h3, PORT_BASE | P_DMA_CLR, 8'h00);
    dma_in = 1'b0;
    chk("dma set wins", dma_f, 1'b1);
    // second reset in mid-run
    rst_n = 1'b0;
    @(negedge clock);
    chk("mid reset", {cpc, ctl1, cs}, 64'h0);
    chk("mid reset flag", dma_f, 1'b0);
    rst_n = 1'b1;
    acc(2'h2, PORT_BASE | P_CS_BASE, 8'h00);
    chk("after reset", {ack, rd, tpc_load}, 10'h200);
    conclude();
  end
endmodule : tb
